// File: hw/hrs_pkg.sv
/*
 hrs_pkg: constants, register map and state type for the hardware return stack.
 assumes a 32-bit APB slave port and a core sequencer on the same pclk domain.
*/
// Functional notes
// - sixteen-entry return stack that wraps by default
// - option: overflow or underflow forces a reset
// - push increments pointer, then stores next address
// - after reset pointer is 0x1F, stack empty
// - empty with reset option: top reads zero
// - empty without reset option: top shows entry 0x0F
// - return loads top, decrements; last pop gives 0x1F
// - without reset option, push on full stack gives pointer 0x10
// - five-bit pointer; msb after push means overflow
// - overflow reset: pc to zero, set cause flag
// - pointer value 31 means stack empty
// - return on empty underflows; reset jumps to zero
// - without reset option, pointer wraps modulo 32; entries indexed modulo sixteen
// - separate overflow and underflow status bits
// - hidden debug stack apart from user entries
// - in debug mode, stack reset becomes breakpoint
// - pointer and top registers give full user access
package hrs_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int HRS_DEPTH = 16;
	localparam int HRS_SP_W = 5;
	localparam int HRS_PC_W = 15;
	localparam int HRS_HI_W = HRS_PC_W - 8;
	localparam logic [HRS_SP_W-1:0] HRS_SP_EMPTY = 5'h1F;
	localparam logic [HRS_SP_W-1:0] HRS_SP_RST = 5'h1F;
	localparam logic [HRS_PC_W-1:0] HRS_PC_RESET_VEC = 15'h0000;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] HRS_OFF_SP = 8'h00;
	localparam logic [7:0] HRS_OFF_TOS_HI = 8'h04;
	localparam logic [7:0] HRS_OFF_TOS_LO = 8'h08;
	localparam logic [7:0] HRS_OFF_CTRL = 8'h0C;
	localparam logic [7:0] HRS_OFF_STAT = 8'h10;
	localparam logic [7:0] HRS_OFF_PWR_CTRL = 8'h14;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int HRS_CTRL_RST_EN = 0;
	localparam int HRS_STAT_OVF = 0;
	localparam int HRS_STAT_UNF = 1;
	localparam int HRS_PWR_STK_RST = 0;
	localparam logic HRS_RST_EN_RST = 1'b0;

	typedef logic [HRS_DEPTH-1:0][HRS_PC_W-1:0] hrs_mem_t;

	typedef struct packed {
		logic [HRS_SP_W-1:0] sp;
		logic [HRS_SP_W-1:0] dsp;
		hrs_mem_t mem;
		hrs_mem_t dmem;
		logic rst_en;
		logic ovf;
		logic unf;
		logic rst_flag;
		logic pc_load;
		logic [HRS_PC_W-1:0] pc_addr;
		logic stack_reset;
		logic dbg_break;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} hrs_state_t;

endpackage : hrs_pkg

// File: hw/hrs_top.sv
/*
 hrs_top: hardware return-address stack with APB register access.
 assumes the core raises one push or pop pulse per instruction and
 applies pc_load / stack_reset on the cycle they are seen.
*/
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module hrs_top
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core sequencer
	input wire logic push_i,
	input wire logic [hrs_pkg::HRS_PC_W-1:0] push_pc_i,
	input wire logic pop_i,
	input wire logic dbg_exec_i,
	input wire logic debug_mode_i,
	output logic pc_load_o,
	output logic [hrs_pkg::HRS_PC_W-1:0] pc_addr_o,
	output logic stack_reset_o,
	output logic debug_break_o
);
	import hrs_pkg::*;

	hrs_state_t q;
	hrs_state_t d;

	// ----------------------------------------
	// combinational helpers
	// ----------------------------------------
	logic [HRS_SP_W-1:0] cur_sp;
	logic [HRS_SP_W-1:0] nsp_push;
	logic [HRS_SP_W-1:0] nsp_pop;
	logic cur_empty;
	logic user_empty;
	logic [HRS_PC_W-1:0] top_word;
	logic [HRS_PC_W-1:0] cur_top;
	logic setup;
	logic acc_wr;
	logic [HRS_PC_W-1:0] edit_word;

	always_comb
	begin
		cur_sp = dbg_exec_i ? q.dsp : q.sp;
		nsp_push = cur_sp + 5'h01;
		nsp_pop = cur_sp - 5'h01;
		cur_empty = (cur_sp == HRS_SP_EMPTY);
		user_empty = (q.sp == HRS_SP_EMPTY);
		// 0x1F indexes entry 0x0F, so the empty read shows it
		top_word = q.mem[q.sp[3:0]];
		cur_top = dbg_exec_i ? q.dmem[cur_sp[3:0]] : q.mem[cur_sp[3:0]];
		setup = psel && !penable;
		acc_wr = psel && penable && pwrite && q.pready;
		edit_word = top_word;
		if (paddr == HRS_OFF_TOS_HI)
		begin
			edit_word[HRS_PC_W-1:8] = pwdata[HRS_HI_W-1:0];
		end
		else
		begin
			edit_word[7:0] = pwdata[7:0];
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.pc_load = 1'b0;
		d.stack_reset = 1'b0;
		d.dbg_break = 1'b0;
		d.pready = 1'b0;
		d.pslverr = 1'b0;

		// register writes first; core traffic below overrides the pointer
		if (acc_wr)
		begin
			unique case (paddr)
				HRS_OFF_SP: d.sp = pwdata[HRS_SP_W-1:0];
				HRS_OFF_TOS_HI, HRS_OFF_TOS_LO:
				begin
					if (!(user_empty && q.rst_en))
					begin
						d.mem[q.sp[3:0]] = edit_word;
					end
				end
				HRS_OFF_CTRL: d.rst_en = pwdata[HRS_CTRL_RST_EN];
				HRS_OFF_STAT:
				begin
					// write one to clear; a new event below still wins
					if (pwdata[HRS_STAT_OVF])
					begin
						d.ovf = 1'b0;
					end
					if (pwdata[HRS_STAT_UNF])
					begin
						d.unf = 1'b0;
					end
				end
				HRS_OFF_PWR_CTRL:
				begin
					if (pwdata[HRS_PWR_STK_RST])
					begin
						d.rst_flag = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end

		// core push: call or interrupt; push wins if both arrive
		if (push_i)
		begin
			if (nsp_push[HRS_SP_W-1] && !dbg_exec_i)
			begin
				d.ovf = 1'b1;
			end
			if (nsp_push[HRS_SP_W-1] && q.rst_en && !dbg_exec_i && !debug_mode_i)
			begin
				d.sp = HRS_SP_RST;
				d.pc_load = 1'b1;
				d.pc_addr = HRS_PC_RESET_VEC;
				d.stack_reset = 1'b1;
				d.rst_flag = 1'b1;
			end
			else
			begin
				if (nsp_push[HRS_SP_W-1] && q.rst_en && !dbg_exec_i)
				begin
					d.dbg_break = 1'b1;
				end
				// full stack goes 0x0F -> 0x10, sharing entry 0x00
				if (dbg_exec_i)
				begin
					d.dsp = nsp_push;
					d.dmem[nsp_push[3:0]] = push_pc_i;
				end
				else
				begin
					d.sp = nsp_push;
					d.mem[nsp_push[3:0]] = push_pc_i;
				end
			end
		end
		else if (pop_i)
		begin
			if (cur_empty && !dbg_exec_i)
			begin
				d.unf = 1'b1;
			end
			if (cur_empty && q.rst_en && !dbg_exec_i && !debug_mode_i)
			begin
				d.sp = HRS_SP_RST;
				d.pc_load = 1'b1;
				d.pc_addr = HRS_PC_RESET_VEC;
				d.stack_reset = 1'b1;
				d.rst_flag = 1'b1;
			end
			else
			begin
				if (cur_empty && q.rst_en && !dbg_exec_i)
				begin
					d.dbg_break = 1'b1;
				end
				d.pc_load = 1'b1;
				d.pc_addr = cur_top;
				if (dbg_exec_i)
				begin
					d.dsp = nsp_pop;
				end
				else
				begin
					d.sp = nsp_pop;
				end
			end
		end

		// read data is staged in setup so the access phase has no wait
		if (setup)
		begin
			d.pready = 1'b1;
			d.prdata = 32'h0000_0000;
			unique case (paddr)
				HRS_OFF_SP: d.prdata[HRS_SP_W-1:0] = q.sp;
				HRS_OFF_TOS_HI:
				begin
					if (!(user_empty && q.rst_en))
					begin
						d.prdata[HRS_HI_W-1:0] = top_word[HRS_PC_W-1:8];
					end
				end
				HRS_OFF_TOS_LO:
				begin
					if (!(user_empty && q.rst_en))
					begin
						d.prdata[7:0] = top_word[7:0];
					end
				end
				HRS_OFF_CTRL: d.prdata[HRS_CTRL_RST_EN] = q.rst_en;
				HRS_OFF_STAT:
				begin
					d.prdata[HRS_STAT_OVF] = q.ovf;
					d.prdata[HRS_STAT_UNF] = q.unf;
				end
				HRS_OFF_PWR_CTRL: d.prdata[HRS_PWR_STK_RST] = q.rst_flag;
				default: d.pslverr = 1'b1;
			endcase
		end
		else if (psel && penable)
		begin
			d.pready = 1'b0;
			d.prdata = 32'h0000_0000;
		end
		else
		begin
			d.prdata = 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.sp <= HRS_SP_RST;
			q.dsp <= HRS_SP_RST;
			q.rst_en <= HRS_RST_EN_RST;
		end
		else
		begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign pc_load_o = q.pc_load;
	assign pc_addr_o = q.pc_addr;
	assign stack_reset_o = q.stack_reset;
	assign debug_break_o = q.dbg_break;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_push_increments: assert property (
		(push_i && !dbg_exec_i && !nsp_push[HRS_SP_W-1] && !(acc_wr && paddr == HRS_OFF_SP))
		|=> (q.sp == $past(q.sp) + 5'h01) && (q.mem[q.sp[3:0]] == $past(push_pc_i)))
		else $error("push did not increment and store");

	chk_full_wraps: assert property (
		(push_i && !dbg_exec_i && q.sp == 5'h0F && !q.rst_en) |=> (q.sp == 5'h10) && q.ovf)
		else $error("push on full stack did not wrap to 0x10");

	chk_pop_loads_top: assert property (
		(pop_i && !push_i && !dbg_exec_i && !user_empty)
		|=> pc_load_o && (pc_addr_o == $past(top_word)) && (q.sp == $past(q.sp) - 5'h01))
		else $error("return did not load top entry");

	chk_last_pop_empty: assert property (
		(pop_i && !push_i && !dbg_exec_i && q.sp == 5'h00 && !(acc_wr && paddr == HRS_OFF_SP))
		|=> q.sp == HRS_SP_EMPTY)
		else $error("popping last entry did not give 0x1F");

	chk_ovf_reset: assert property (
		(push_i && !dbg_exec_i && !debug_mode_i && q.rst_en && nsp_push[HRS_SP_W-1])
		|=> stack_reset_o && pc_load_o && pc_addr_o == HRS_PC_RESET_VEC && q.rst_flag
		##1 !stack_reset_o)
		else $error("overflow reset not taken");

	chk_unf_reset: assert property (
		(pop_i && !push_i && !dbg_exec_i && !debug_mode_i && q.rst_en && user_empty)
		|=> stack_reset_o && pc_addr_o == HRS_PC_RESET_VEC && q.unf && q.rst_flag)
		else $error("underflow reset not taken");

	chk_debug_break: assert property (
		(push_i && !dbg_exec_i && debug_mode_i && q.rst_en && nsp_push[HRS_SP_W-1])
		|=> debug_break_o && !stack_reset_o)
		else $error("debug mode did not turn stack reset into a break");

	chk_empty_reads_zero: assert property (
		(setup && !pwrite && user_empty && q.rst_en && paddr == HRS_OFF_TOS_LO)
		|=> pready && prdata == 32'h0000_0000)
		else $error("empty top read not zero");

	chk_flag_sticky: assert property (
		q.ovf && !(acc_wr && paddr == HRS_OFF_STAT && pwdata[HRS_STAT_OVF]) |=> q.ovf)
		else $error("overflow flag lost without clear");

	chk_debug_hidden: assert property (
		(dbg_exec_i && (push_i || pop_i) && !acc_wr) |=> $stable(q.sp) && $stable(q.mem))
		else $error("debug traffic touched user stack");

	chk_reset_empty: assert property (
		!$past(presetn)
		|-> (q.sp == HRS_SP_RST) && (q.dsp == HRS_SP_RST) && !q.rst_en && !stack_reset_o)
		else $error("stack not empty after reset");

	chk_empty_reads_entry: assert property (
		(setup && !pwrite && user_empty && !q.rst_en && paddr == HRS_OFF_TOS_LO)
		|=> (prdata[7:0] == $past(q.mem[4'hF][7:0])) && (prdata[31:8] == 24'h00_0000))
		else $error("empty top read did not show entry 0x0F");

	chk_ptr_read: assert property (
		(setup && !pwrite && paddr == HRS_OFF_SP)
		|=> prdata == {27'h000_0000, $past(q.sp)})
		else $error("pointer read mismatch");

	chk_ptr_write: assert property (
		(acc_wr && paddr == HRS_OFF_SP && !push_i && !pop_i)
		|=> q.sp == $past(pwdata[HRS_SP_W-1:0]))
		else $error("pointer write not taken");

	chk_unmapped_err: assert property (
		(setup && (paddr > HRS_OFF_PWR_CTRL || paddr[1:0] != 2'b00))
		|=> pready && pslverr && (prdata == 32'h0000_0000))
		else $error("unmapped address not refused");

	chk_top_write: assert property (
		(acc_wr && paddr == HRS_OFF_TOS_LO && !push_i && !pop_i && !(user_empty && q.rst_en))
		|=> q.mem[q.sp[3:0]][7:0] == $past(pwdata[7:0]))
		else $error("top low write did not land");

	chk_top_refused: assert property (
		(acc_wr && (paddr == HRS_OFF_TOS_HI || paddr == HRS_OFF_TOS_LO) && user_empty && q.rst_en
		&& !push_i && !pop_i) |=> $stable(q.mem))
		else $error("top write landed on empty stack");

	chk_unf_flag: assert property (
		(pop_i && !push_i && !dbg_exec_i && user_empty) |=> q.unf)
		else $error("underflow flag not set");

	chk_ovf_flag: assert property (
		(push_i && !dbg_exec_i && (q.sp[HRS_SP_W-1] || q.sp == 5'h0F) && !user_empty) |=> q.ovf)
		else $error("overflow flag not set");

	chk_wrap_keeps: assert property (
		(push_i && !dbg_exec_i && !q.rst_en && q.sp == 5'h0F)
		|=> !stack_reset_o && !pc_load_o && (q.mem[0] == $past(push_pc_i)))
		else $error("wrapping push did not reuse entry 0x00");

	chk_empty_pop_wraps: assert property (
		(pop_i && !push_i && !dbg_exec_i && user_empty && !q.rst_en)
		|=> (q.sp == 5'h1E) && pc_load_o && !stack_reset_o)
		else $error("empty pop did not wrap to 0x1E");

	chk_no_reset_off: assert property (
		!q.rst_en |=> !stack_reset_o)
		else $error("stack reset taken with option off");

	chk_debug_unf_break: assert property (
		(pop_i && !push_i && !dbg_exec_i && debug_mode_i && q.rst_en && user_empty)
		|=> debug_break_o && !stack_reset_o && (q.sp == 5'h1E))
		else $error("debug mode underflow did not break");

endmodule : hrs_top

// File: sim/hrs_core.sv
/*
 hrs_core: behavioural core sequencer that pushes and pops the return stack.
 assumes it shares pclk with the stack and that one caller uses op at a time.
*/
`timescale 1ns/1ns
module hrs_core
(
	// clock
	input wire logic pclk,
	// to stack
	output logic push,
	output logic [hrs_pkg::HRS_PC_W-1:0] push_pc,
	output logic pop,
	output logic dbg_exec,
	output logic debug_mode,
	// from stack
	input wire logic pc_load,
	input wire logic [hrs_pkg::HRS_PC_W-1:0] pc_addr,
	input wire logic stack_reset,
	input wire logic debug_break
);
	import hrs_pkg::*;

	initial
	begin
		push = 1'b0;
		pop = 1'b0;
		push_pc = '0;
		dbg_exec = 1'b0;
		debug_mode = 1'b0;
	end

	// -------------------------------------
	// one call or return per op, never while software edits the stack
	// -------------------------------------
	task automatic op(input logic p, input logic [HRS_PC_W-1:0] pc,
		output logic [2:0] r, output logic [HRS_PC_W-1:0] a);
		@(posedge pclk);
		push <= p;
		pop <= !p;
		push_pc <= pc;
		@(posedge pclk);
		push <= 1'b0;
		pop <= 1'b0;
		// address bus is garbage once the pulse ends
		push_pc <= ~pc;
		#1;
		r = {pc_load, stack_reset, debug_break};
		a = pc_addr;
	endtask : op

	task automatic mode(input logic ex, input logic dm);
		@(posedge pclk);
		dbg_exec <= ex;
		debug_mode <= dm;
	endtask : mode
endmodule : hrs_core

// File: sim/tb.sv
/*
 tb: self-checking bench for hrs_top over apb and the core model.
 assumes zero-wait apb answers and one-cycle-late core pulses.
*/
`timescale 1ns/1ns
module tb;
	import hrs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic push, pop, dbg_exec, debug_mode, pc_load, stack_reset, debug_break;
	logic [HRS_PC_W-1:0] push_pc, pc_addr, pa;
	logic [2:0] r;
	int err_total = 0;
	int check_count = 0;

	hrs_top hrs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .push_i(push), .push_pc_i(push_pc), .pop_i(pop), .dbg_exec_i(dbg_exec),
		.debug_mode_i(debug_mode), .pc_load_o(pc_load), .pc_addr_o(pc_addr),
		.stack_reset_o(stack_reset), .debug_break_o(debug_break));
	hrs_core hrs_core_i (.pclk(pclk), .push(push), .push_pc(push_pc), .pop(pop),
		.dbg_exec(dbg_exec), .debug_mode(debug_mode), .pc_load(pc_load), .pc_addr(pc_addr),
		.stack_reset(stack_reset), .debug_break(debug_break));

	// -------------------------------------
	// shared helpers
	// -------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not look like the last transfer
		paddr <= ~a;
		pwdata <= ~d;
		if (n >= 50)
			chk(32'h1, 32'h0);
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	task automatic summarize;
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// -------------------------------------
	// scenarios
	// -------------------------------------
	task automatic t_fill;
		rchk(HRS_OFF_SP, 32'h1F);
		rchk(HRS_OFF_CTRL, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			hrs_core_i.op(1'b1, 15'h4A30 + 15'(i), r, pa);
			rchk(HRS_OFF_SP, 32'(i));
			rchk(HRS_OFF_TOS_LO, 32'h30 + 32'(i));
		end
		rchk(HRS_OFF_TOS_HI, 32'h4A);
		rchk(HRS_OFF_STAT, 32'h0);
		hrs_core_i.op(1'b1, 15'h7E55, r, pa);
		chk({29'h0, r}, 32'h0);
		rchk(HRS_OFF_SP, 32'h10);
		rchk(HRS_OFF_STAT, 32'h1);
		rchk(HRS_OFF_TOS_HI, 32'h7E);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({29'h0, r}, 32'h4);
		chk({17'h0, pa}, 32'h7E55);
		rchk(HRS_OFF_SP, 32'h0F);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({17'h0, pa}, 32'h4A3F);
	endtask : t_fill

	task automatic t_under;
		apb(1'b1, HRS_OFF_SP, 32'h0);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({17'h0, pa}, 32'h7E55);
		rchk(HRS_OFF_SP, 32'h1F);
		apb(1'b1, HRS_OFF_STAT, 32'h3);
		rchk(HRS_OFF_TOS_LO, 32'h3F);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({29'h0, r}, 32'h4);
		chk({17'h0, pa}, 32'h4A3F);
		rchk(HRS_OFF_SP, 32'h1E);
		rchk(HRS_OFF_STAT, 32'h2);
		rchk(HRS_OFF_PWR_CTRL, 32'h0);
	endtask : t_under

	task automatic t_edit;
		apb(1'b1, HRS_OFF_SP, 32'h5);
		apb(1'b1, HRS_OFF_TOS_HI, 32'h12);
		apb(1'b1, HRS_OFF_TOS_LO, 32'h34);
		rchk(HRS_OFF_TOS_HI, 32'h12);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({17'h0, pa}, 32'h1234);
		rchk(HRS_OFF_SP, 32'h4);
	endtask : t_edit

	task automatic t_reset;
		apb(1'b1, HRS_OFF_STAT, 32'h3);
		apb(1'b1, HRS_OFF_CTRL, 32'h1);
		apb(1'b1, HRS_OFF_SP, 32'h1F);
		rchk(HRS_OFF_TOS_LO, 32'h0);
		rchk(HRS_OFF_TOS_HI, 32'h0);
		apb(1'b1, HRS_OFF_TOS_LO, 32'h55);
		rchk(HRS_OFF_TOS_LO, 32'h0);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({29'h0, r}, 32'h6);
		chk({17'h0, pa}, 32'h0);
		rchk(HRS_OFF_PWR_CTRL, 32'h1);
		apb(1'b1, HRS_OFF_PWR_CTRL, 32'h1);
		apb(1'b1, HRS_OFF_SP, 32'h0F);
		hrs_core_i.op(1'b1, 15'h0123, r, pa);
		chk({29'h0, r}, 32'h6);
		chk({17'h0, pa}, 32'h0);
		rchk(HRS_OFF_PWR_CTRL, 32'h1);
		rchk(HRS_OFF_STAT, 32'h3);
		hrs_core_i.mode(1'b0, 1'b1);
		apb(1'b1, HRS_OFF_SP, 32'h1F);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({30'h0, r[1:0]}, 32'h1);
		hrs_core_i.op(1'b1, 15'h0456, r, pa);
		chk({29'h0, r}, 32'h1);
		hrs_core_i.mode(1'b0, 1'b0);
		apb(1'b1, HRS_OFF_CTRL, 32'h0);
		rchk(HRS_OFF_TOS_LO, 32'h56);
	endtask : t_reset

	task automatic t_debug;
		apb(1'b1, HRS_OFF_SP, 32'h3);
		hrs_core_i.mode(1'b1, 1'b0);
		hrs_core_i.op(1'b1, 15'h2BCD, r, pa);
		hrs_core_i.op(1'b0, 15'h0, r, pa);
		chk({17'h0, pa}, 32'h2BCD);
		hrs_core_i.mode(1'b0, 1'b0);
		rchk(HRS_OFF_SP, 32'h3);
		rchk(HRS_OFF_TOS_LO, 32'h33);
		rchk(8'h18, 32'h0);
		chk({31'h0, er}, 32'h1);
	endtask : t_debug

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial
	begin
		#300000;
		err_total++;
		summarize();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_fill();
		t_under();
		t_edit();
		t_reset();
		t_debug();
		summarize();
	end
endmodule : tb
